// ==== design/basic_timer_watchdog.sv ====
// file: basic timer control register, counter and watchdog reset request
// Overview of operation
// - watchdog off only when code field is 1010
// - select field picks divide 4096/1024/128/16
// - writing counter-clear one zeroes counter
// - counter-clear bit reads back zero afterwards
// - divider-clear one zeroes the shared frequency divider
// - divider-clear bit reads back zero afterwards
// - control register resets to all zeros
// - prescaler divides the selected system clock
`timescale 1ns/1ps
module basic_timer_watchdog
  import wdt_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_b_i,
  // selected system clock enable (main or sub oscillator)
  input  wire logic       fxx_en_i,
  // internal register bus
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // outputs
  output logic      [7:0] counter_o,
  output logic      [DIV_WIDTH-1:0] tc_div_o,
  output logic            wdt_enabled_o,
  output logic            sys_reset_req_o
);
  logic       rst_s1_r;
  logic       rst_s2_r;
  logic       rst_b;
  logic [5:0] ctrl_r;
  logic [5:0] ctrl_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic       req_r;
  logic       req_nxt;
  logic       wr_ctrl;
  logic       cnt_clr;
  logic       div_clr;
  logic       tick;
  logic       wdt_on;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_b = rst_s2_r;

  // write decode; the two clear bits are strobes and never stored
  assign wr_ctrl = reg_wr_i && (reg_addr_i == ADDR_CONTROL);
  assign cnt_clr = wr_ctrl && reg_wdata_i[CNT_CLR_BIT];
  assign div_clr = wr_ctrl && reg_wdata_i[DIV_CLR_BIT];
  assign wdt_on  = (ctrl_r[5:2] != DISABLE_CODE);

  tick_prescaler u_prescaler (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b),
    .fxx_en_i  (fxx_en_i),
    .clear_i   (div_clr),
    .sel_i     (ctrl_r[1:0]),
    .tick_o    (tick),
    .tc_div_o  (tc_div_o)
  );

  // next state of control, counter and the reset request
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    cnt_nxt  = cnt_r;
    req_nxt  = 1'b0;
    if (wr_ctrl)
    begin
      ctrl_nxt = reg_wdata_i[7:2];
    end
    if (cnt_clr)
    begin
      cnt_nxt = COUNTER_RESET;
    end
    else if (tick)
    begin
      cnt_nxt = cnt_r + 8'h01;
      // a clear in the same cycle as the wrap wins, so software that kicks in time never resets
      req_nxt = wdt_on && (cnt_r == 8'hff);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_r <= CONTROL_RESET[7:2];
      cnt_r  <= COUNTER_RESET;
      req_r  <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      cnt_r  <= cnt_nxt;
      req_r  <= req_nxt;
    end
  end

  // read mux: clear bits always read as zero, unmapped reads zero
  always_comb
  begin
    if (reg_addr_i == ADDR_CONTROL)
    begin
      reg_rdata_o = {ctrl_r, 2'b00};
    end
    else if (reg_addr_i == ADDR_COUNTER)
    begin
      reg_rdata_o = cnt_r;
    end
    else
    begin
      reg_rdata_o = 8'h00;
    end
  end

  assign counter_o       = cnt_r;
  assign wdt_enabled_o   = wdt_on;
  assign sys_reset_req_o = req_r;

  chk_code_disables: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    (reg_addr_i == ADDR_CONTROL && reg_rdata_o[7:4] == DISABLE_CODE) |-> !wdt_enabled_o)
    else $error("disable code decode wrong");
  chk_cnt_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    cnt_clr |=> counter_o == 8'h00)
    else $error("counter not cleared");
  chk_clr_reads_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    (reg_addr_i == ADDR_CONTROL) |-> reg_rdata_o[1:0] == 2'b00)
    else $error("clear bits read nonzero");
  chk_div_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    div_clr |=> tc_div_o == 12'h000 ##1 (reg_addr_i != ADDR_CONTROL || reg_rdata_o[0] == 1'b0))
    else $error("divider clear failed");
  chk_reset_zero: assert property (@(posedge clk_sys_i)
    $rose(rst_b) |-> (ctrl_r == 6'h00 && wdt_enabled_o))
    else $error("control not zero after reset");
  chk_tick_count: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    (tick && !cnt_clr) |=> counter_o == $past(counter_o) + 8'h01)
    else $error("counter did not step");
  chk_hold_no_tick: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    (!tick && !cnt_clr) |=> $stable(counter_o))
    else $error("counter moved without tick");
  chk_overflow_req: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    (tick && !cnt_clr && cnt_r == 8'hff && wdt_on) |=> sys_reset_req_o ##1 !sys_reset_req_o || tick)
    else $error("overflow missed reset request");
  chk_no_req_disabled: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    !wdt_on |=> !sys_reset_req_o)
    else $error("reset request while disabled");
  chk_sel_fast: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    (ctrl_r[1:0] == 2'b11 && fxx_en_i && !div_clr && tc_div_o[3:0] == 4'hf && !wr_ctrl) |=> tick)
    else $error("divide by 16 tick missing");

  // writing the disable pattern turns the watchdog off on the next cycle
  chk_code_write_off: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    (wr_ctrl && reg_wdata_i[7:4] == DISABLE_CODE) |=> !wdt_enabled_o)
    else $error("watchdog still on after disable code");

  // any other pattern keeps it on, so a stray write cannot disarm it
  chk_code_write_on: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    (wr_ctrl && reg_wdata_i[7:4] != DISABLE_CODE) |=> wdt_enabled_o)
    else $error("watchdog off with wrong code");

  // select field is stored as written
  chk_sel_stored: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    wr_ctrl |=> ctrl_r[1:0] == $past(reg_wdata_i[3:2]))
    else $error("select field not stored");

  // counter clear seen from the bus side
  chk_cnt_clr_write: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    (wr_ctrl && reg_wdata_i[CNT_CLR_BIT]) |=> counter_o == COUNTER_RESET)
    else $error("counter clear write ignored");

  // a write with the clear bit low must not disturb the count
  chk_no_clear_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    (wr_ctrl && !reg_wdata_i[CNT_CLR_BIT] && !tick) |=> $stable(counter_o))
    else $error("counter moved on write without clear");

  // both clear bits already read zero the cycle after the write
  chk_clr_bits_after: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    wr_ctrl |=> (reg_addr_i != ADDR_CONTROL || reg_rdata_o[1:0] == 2'b00))
    else $error("clear bit stuck after write");

  // divider clear seen from the bus side
  chk_div_write_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    (wr_ctrl && reg_wdata_i[DIV_CLR_BIT]) |=> tc_div_o == DIVIDER_RESET)
    else $error("divider clear write ignored");

  // without a clear the shared divider steps once per selected clock edge
  chk_div_steps: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    (rst_b && fxx_en_i && !div_clr) |=> tc_div_o == $past(tc_div_o) + 12'h001)
    else $error("divider did not step");

  // a stopped system clock freezes the divider
  chk_div_frozen: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    (rst_b && !fxx_en_i && !div_clr) |=> $stable(tc_div_o))
    else $error("divider moved without clock");

  // wrap from the top value back to zero
  chk_wrap_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    (tick && !cnt_clr && cnt_r == 8'hff) |=> counter_o == 8'h00)
    else $error("counter did not wrap");

  // request is a single-cycle pulse
  chk_req_one_cycle: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    sys_reset_req_o |=> !sys_reset_req_o)
    else $error("reset request too long");

  // request only ever follows a wrap
  chk_req_needs_wrap: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    sys_reset_req_o |-> ($past(cnt_r) == 8'hff && counter_o == 8'h00))
    else $error("reset request without overflow");

  // a kick in the wrap cycle wins over the request
  chk_clear_beats_wrap: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    cnt_clr |=> !sys_reset_req_o)
    else $error("reset request despite clear");

  // control only changes on a write
  chk_ctrl_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_b)
    !wr_ctrl |=> $stable(ctrl_r))
    else $error("control changed without write");
endmodule

// ==== design/tick_prescaler.sv ====
// file: free-running divider of the selected system clock with tick select
`timescale 1ns/1ps
module tick_prescaler
  import wdt_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_b_i,
  // control
  input  wire logic       fxx_en_i,
  input  wire logic       clear_i,
  input  wire logic [1:0] sel_i,
  // tick out, one cycle
  output logic            tick_o,
  // second divider tap for the other timer/counters
  output logic [DIV_WIDTH-1:0] tc_div_o
);
  logic [DIV_WIDTH-1:0] div_r;
  logic [DIV_WIDTH-1:0] div_nxt;
  logic                 tick_r;
  logic                 tick_nxt;

  // terminal count of the selected ratio
  function automatic logic [DIV_WIDTH-1:0] last_count(input logic [1:0] s);
    case (s)
      2'b00:   last_count = DIV_WIDTH'(DIV_SEL0 - 1);
      2'b01:   last_count = DIV_WIDTH'(DIV_SEL1 - 1);
      2'b10:   last_count = DIV_WIDTH'(DIV_SEL2 - 1);
      default: last_count = DIV_WIDTH'(DIV_SEL3 - 1);
    endcase
  endfunction

  // ratios are powers of two so a masked compare tracks the wrap of the free counter
  always_comb
  begin
    div_nxt  = div_r;
    tick_nxt = 1'b0;
    if (clear_i)
    begin
      div_nxt = DIVIDER_RESET;
    end
    else if (fxx_en_i)
    begin
      div_nxt  = div_r + 1'b1;
      tick_nxt = ((div_r & last_count(sel_i)) == last_count(sel_i));
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      div_r  <= DIVIDER_RESET;
      tick_r <= 1'b0;
    end
    else
    begin
      div_r  <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_o   = tick_r;
  assign tc_div_o = div_r;

  chk_clear_zeroes: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    clear_i |=> (div_r == DIVIDER_RESET && !tick_r))
    else $error("divider not cleared");
endmodule

// ==== design/wdt_pkg.sv ====
// package: constants for the basic timer / watchdog block
package wdt_pkg;
  // register address on the internal register bus
  localparam logic [7:0] ADDR_CONTROL   = 8'hd3;
  localparam logic [7:0] ADDR_COUNTER   = 8'hfd;
  localparam logic [7:0] CONTROL_RESET  = 8'h00;
  // field positions
  localparam int         CODE_LSB       = 4;
  localparam int         SEL_LSB        = 2;
  localparam int         CNT_CLR_BIT    = 1;
  localparam int         DIV_CLR_BIT    = 0;
  localparam logic [3:0] DISABLE_CODE   = 4'ha;
  // prescaler divide ratios
  localparam int         DIV_SEL0       = 4096;
  localparam int         DIV_SEL1       = 1024;
  localparam int         DIV_SEL2       = 128;
  localparam int         DIV_SEL3       = 16;
  localparam int         DIV_WIDTH      = 12;
  localparam logic [7:0] COUNTER_RESET  = 8'h00;
  localparam logic [DIV_WIDTH-1:0] DIVIDER_RESET = 12'h000;
endpackage

// ==== sim/basic_timer_watchdog_tb.sv ====
// testbench: directed scenarios for the basic timer watchdog block
`timescale 1ns/1ps
module basic_timer_watchdog_tb;
  import wdt_pkg::*;
  logic                 clk_sys_i;
  logic                 rst_b_i;
  logic                 fxx_en_i;
  logic                 reg_wr_i;
  logic [7:0]           reg_addr_i;
  logic [7:0]           reg_wdata_i;
  logic [7:0]           reg_rdata_o;
  logic [7:0]           counter_o;
  logic [DIV_WIDTH-1:0] tc_div_o;
  logic                 wdt_enabled_o;
  logic                 sys_reset_req_o;
  int                   failures;
  int                   n_tests;

  basic_timer_watchdog dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .fxx_en_i(fxx_en_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .counter_o(counter_o), .tc_div_o(tc_div_o), .wdt_enabled_o(wdt_enabled_o),
    .sys_reset_req_o(sys_reset_req_o));

  // 125 MHz system clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    if (failures == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // one-cycle write, address parked on the control register afterwards
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_sys_i);
    reg_wr_i = 1'b0;
    reg_addr_i = ADDR_CONTROL;
  endtask

  // cycles until the counter moves; bounded so a dead prescaler ends the run
  task automatic wait_cnt(output int n);
    logic [7:0] c;
    c = counter_o;
    n = 0;
    while (counter_o === c && n < 5000)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n >= 5000)
    begin
      failures++;
      complete_run();
    end
  endtask

  task automatic t_code;
    chk(reg_rdata_o, CONTROL_RESET);
    chk(wdt_enabled_o, 1'b1);
    wr(ADDR_CONTROL, 8'ha0);
    chk(wdt_enabled_o, 1'b0);
    chk(reg_rdata_o, 8'ha0);
    wr(ADDR_CONTROL, 8'hb0);
    chk(wdt_enabled_o, 1'b1);
    wr(ADDR_CONTROL, 8'h20);
    wr(8'hd4, 8'ha0);
    chk(wdt_enabled_o, 1'b1);
  endtask

  task automatic t_rate;
    int n;
    int ratio [4];
    ratio = '{DIV_SEL0, DIV_SEL1, DIV_SEL2, DIV_SEL3};
    for (int s = 0; s < 4; s++)
    begin
      wr(ADDR_CONTROL, {4'ha, 2'(s), 2'b00});
      wait_cnt(n);
      wait_cnt(n);
      chk(16'(n), 16'(ratio[s]));
    end
  endtask

  task automatic t_clear;
    int n;
    logic [7:0] c;
    logic [DIV_WIDTH-1:0] d;
    wr(ADDR_CONTROL, 8'hae);
    chk(counter_o, 8'h00);
    chk(reg_rdata_o, 8'hac);
    wait_cnt(n);
    chk(counter_o, 8'h01);
    wr(ADDR_CONTROL, 8'had);
    chk(tc_div_o, 16'h0000);
    chk(reg_rdata_o, 8'hac);
    // stopping the selected clock must freeze the shared divider and counter
    fxx_en_i = 1'b0;
    c = counter_o;
    d = tc_div_o;
    reg_addr_i = ADDR_COUNTER;
    repeat (100) @(negedge clk_sys_i);
    chk(counter_o, c);
    chk(tc_div_o, d);
    chk(reg_rdata_o, 8'h01);
    reg_addr_i = ADDR_CONTROL;
    fxx_en_i = 1'b1;
  endtask

  task automatic t_wdt;
    int n;
    int seen;
    wr(ADDR_CONTROL, 8'h0e);
    n = 0;
    while (sys_reset_req_o !== 1'b1 && n < 5000)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n >= 5000)
    begin
      failures++;
      complete_run();
    end
    chk(counter_o, 8'h00);
    chk(16'(n >= 4080 && n <= 4100), 16'h0001);
    @(negedge clk_sys_i);
    chk(sys_reset_req_o, 1'b0);
    wr(ADDR_CONTROL, 8'hae);
    seen = 0;
    repeat (4300)
    begin
      @(negedge clk_sys_i);
      seen += (sys_reset_req_o !== 1'b0);
    end
    chk(16'(seen), 16'h0000);
  endtask

  initial
  begin
    failures = 0;
    n_tests = 0;
    rst_b_i = 1'b0;
    fxx_en_i = 1'b1;
    reg_wr_i = 1'b0;
    reg_addr_i = ADDR_CONTROL;
    reg_wdata_i = 8'h00;
    repeat (4) @(negedge clk_sys_i);
    rst_b_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    t_code();
    t_rate();
    t_clear();
    t_wdt();
    complete_run();
  end
endmodule
